// ### core/fgc_defines.svh
// Register offsets, field positions and reset values of the fuel gauge registers
`ifndef FGC_DEFINES_SVH
`define FGC_DEFINES_SVH

`define FGC_ADDR_CONFIG      8'h18
`define FGC_ADDR_COMMAND     8'h19
`define FGC_ADDR_DIS_LOW     8'h1A
`define FGC_ADDR_DIS_HIGH    8'h1B
`define FGC_ADDR_CHG_LOW     8'h1C
`define FGC_ADDR_CHG_HIGH    8'h1D

`define FGC_CFG_EN_BIT       7
`define FGC_CFG_CAL_BIT      6
`define FGC_CFG_SEL_HI       5
`define FGC_CFG_SEL_LO       4
`define FGC_CFG_DIR_BIT      3

`define FGC_CMD_SNAP_BIT     7
`define FGC_CMD_CLR_DIS_BIT  6
`define FGC_CMD_CLR_CHG_BIT  5

`define FGC_CFG_RESET        8'h00
`define FGC_LATCH_RESET      16'h0000
`define FGC_RDATA_RESET      8'h00

`endif

// ### core/fgc_pkg.sv
// Types shared by the fuel gauge register block
package fgc_pkg;

  typedef enum logic [1:0] {
    FGC_SRC_CMD   = 2'h0,
    FGC_SRC_ADC   = 2'h1,
    FGC_SRC_TMR_A = 2'h2,
    FGC_SRC_TMR_B = 2'h3
  } fgc_src_t;

endpackage

// ### core/fgc_counter.sv
// Increment-only coulomb counter with clear and wrap pulse
`timescale 1ns/1ps
module fgc_counter #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  output logic [W-1:0]      cnt_o,
  output logic              ovf_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         ovf_q;
  logic         ovf_d;

  always_comb begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    // Clear drops a tick arriving in the same cycle
    if (clr_i) begin
      cnt_d = '0;
    end else if (inc_i) begin
      cnt_d = cnt_q + W'(1); // RULE16
      ovf_d = &cnt_q; // RULE16
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign cnt_o = cnt_q;
  assign ovf_o = ovf_q;
endmodule

// ### core/fgc_latch_arb.sv
// Latch source selection and edge detection of latch events
`timescale 1ns/1ps
module fgc_latch_arb
  import fgc_pkg::*;
(
  input  wire logic     sys_clk_i,
  input  wire logic     srst_i,
  input  fgc_src_t      sel_i,
  input  wire logic     snap_cmd_i,
  input  wire logic     adc_busy_i,
  input  wire logic     timer_a_ovf_i,
  input  wire logic     timer_b_ovf_i,
  output logic          latch_o
);
  logic adc_q;
  logic ta_q;
  logic tb_q;
  logic adc_edge;
  logic ta_edge;
  logic tb_edge;

  always_comb begin
    adc_edge = adc_q ^ adc_busy_i; // RULE5
    ta_edge  = timer_a_ovf_i & ~ta_q;
    tb_edge  = timer_b_ovf_i & ~tb_q;
    latch_o  = 1'b0;
    unique case (sel_i)
      FGC_SRC_CMD:   latch_o = snap_cmd_i; // RULE4
      FGC_SRC_ADC:   latch_o = adc_edge; // RULE5
      FGC_SRC_TMR_A: latch_o = ta_edge; // RULE6
      FGC_SRC_TMR_B: latch_o = tb_edge; // RULE7
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      adc_q <= 1'b0;
      ta_q  <= 1'b0;
      tb_q  <= 1'b0;
    end else begin
      adc_q <= adc_busy_i;
      ta_q  <= timer_a_ovf_i;
      tb_q  <= timer_b_ovf_i;
    end
  end
endmodule

// ### core/fgc_regs.sv
// Fuel gauge configuration, command and latched count registers
`timescale 1ns/1ps
`include "fgc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - Config bit 7 enables gauge, reset off
// RULE2 - Config bit 6 shorts inputs, tristates sense
// RULE3 - Config bits 5:4 choose latch source
// RULE4 - Source 00: latch only by command
// RULE5 - Source 01: latch at ADC start, end
// RULE6 - Source 10: latch on timer A overflow
// RULE7 - Source 11: latch on timer B overflow
// RULE8 - Config bit 3 reads current direction only
// RULE9 - Command bit snapshots both counts
// RULE10 - Command clears discharge counter
// RULE11 - Command clears charge counter
// RULE12 - Commands ignored unless source is 00
// RULE13 - Discharge latch readable as two bytes
// RULE14 - Charge latch readable as two bytes
// RULE15 - Snapshot command is command bit 7
// RULE16 - Counters increment, wrap, signal overflow
// RULE17 - Snapshot leaves running counters untouched
// RULE18 - Snapshot never sees partial count
// RULE19 - Clear bits 6 and 5, rest ignored
// RULE20 - Reserved config bits read zero
module fgc_regs
  import fgc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  port_addr_i,
  input  wire logic [7:0]  port_wdata_i,
  input  wire logic        port_wr_i,
  input  wire logic        port_rd_i,
  output logic      [7:0]  port_rdata_o,
  input  wire logic        charge_tick_i,
  input  wire logic        discharge_tick_i,
  input  wire logic        dir_charge_i,
  input  wire logic        adc_busy_i,
  input  wire logic        timer_a_ovf_i,
  input  wire logic        timer_b_ovf_i,
  output logic             gauge_enable_o,
  output logic             input_short_cal_o,
  output logic             sense_pos_hiz_o,
  output logic             charge_ovf_o,
  output logic             discharge_ovf_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic             gauge_enable_bit_q;
  logic             gauge_enable_bit_d;
  logic             input_short_cal_q;
  logic             input_short_cal_d;
  fgc_src_t         latch_source_sel_q;
  fgc_src_t         latch_source_sel_d;
  logic             current_dir_flag_q;
  logic             current_dir_flag_d;
  logic             cal_out_q;
  logic             cal_out_d;
  logic             hiz_q;
  logic             hiz_d;
  logic             en_out_q;
  logic             en_out_d;
  logic [CNT_W-1:0] dis_latch_q;
  logic [CNT_W-1:0] dis_latch_d;
  logic [CNT_W-1:0] chg_latch_q;
  logic [CNT_W-1:0] chg_latch_d;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;
  logic             cfg_wr;
  logic             cmd_wr;
  logic             cmd_live;
  logic             snapshot_cmd;
  logic             clear_discharge_cnt;
  logic             clear_charge_cnt;
  logic             chg_inc;
  logic             dis_inc;
  logic             latch_evt;
  logic [CNT_W-1:0] chg_cnt;
  logic [CNT_W-1:0] dis_cnt;
  logic             chg_ovf;
  logic             dis_ovf;
  logic             hit_cfg;
  logic             hit_cmd;
  logic             hit_dis_lo;
  logic             hit_dis_hi;
  logic             hit_chg_lo;
  logic             hit_chg_hi;
  logic [7:0]       cfg_byte;
  logic [7:0]       dis_lo_byte;
  logic [7:0]       dis_hi_byte;
  logic [7:0]       chg_lo_byte;
  logic [7:0]       chg_hi_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Whole-byte compare, so no neighbouring offset aliases onto these registers;
  // the cost is six 8-bit comparators instead of a shared upper-bit match
  always_comb begin
    hit_cfg    = (port_addr_i == `FGC_ADDR_CONFIG);
    hit_cmd    = (port_addr_i == `FGC_ADDR_COMMAND);
    hit_dis_lo = (port_addr_i == `FGC_ADDR_DIS_LOW);
    hit_dis_hi = (port_addr_i == `FGC_ADDR_DIS_HIGH);
    hit_chg_lo = (port_addr_i == `FGC_ADDR_CHG_LOW);
    hit_chg_hi = (port_addr_i == `FGC_ADDR_CHG_HIGH);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    cfg_wr = port_wr_i && hit_cfg;
    cmd_wr = port_wr_i && hit_cmd;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb begin
    // Command register only acts in processor latch mode
    cmd_live            = cmd_wr && (latch_source_sel_q == FGC_SRC_CMD); // RULE12
    // Zero bits and bits 4..0 carry no action
    snapshot_cmd        = cmd_live && port_wdata_i[`FGC_CMD_SNAP_BIT]; // RULE15
    clear_discharge_cnt = cmd_live && port_wdata_i[`FGC_CMD_CLR_DIS_BIT]; // RULE19
    clear_charge_cnt    = cmd_live && port_wdata_i[`FGC_CMD_CLR_CHG_BIT]; // RULE19
    // Counting needs the block switched on
    chg_inc             = gauge_enable_bit_q && charge_tick_i;
    dis_inc             = gauge_enable_bit_q && discharge_tick_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Running counters
  fgc_counter #(
    .W         (CNT_W)
  ) u_chg_cnt (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (chg_inc),
    .clr_i     (clear_charge_cnt), // RULE11
    .cnt_o     (chg_cnt),
    .ovf_o     (chg_ovf)
  );

  fgc_counter #(
    .W         (CNT_W)
  ) u_dis_cnt (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (dis_inc),
    .clr_i     (clear_discharge_cnt), // RULE10
    .cnt_o     (dis_cnt),
    .ovf_o     (dis_ovf)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Latch source
  fgc_latch_arb u_arb (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .sel_i         (latch_source_sel_q), // RULE3
    .snap_cmd_i    (snapshot_cmd), // RULE9
    .adc_busy_i    (adc_busy_i),
    .timer_a_ovf_i (timer_a_ovf_i),
    .timer_b_ovf_i (timer_b_ovf_i),
    .latch_o       (latch_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register
  always_comb begin
    gauge_enable_bit_d = gauge_enable_bit_q;
    input_short_cal_d  = input_short_cal_q;
    latch_source_sel_d = latch_source_sel_q;
    if (cfg_wr) begin
      gauge_enable_bit_d = port_wdata_i[`FGC_CFG_EN_BIT]; // RULE1
      input_short_cal_d  = port_wdata_i[`FGC_CFG_CAL_BIT]; // RULE2
      latch_source_sel_d = fgc_src_t'(port_wdata_i[`FGC_CFG_SEL_HI:`FGC_CFG_SEL_LO]); // RULE3
    end
    // Direction bit follows the sense input; writes never reach it
    current_dir_flag_d = dir_charge_i; // RULE8
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      gauge_enable_bit_q <= 1'(`FGC_CFG_RESET >> `FGC_CFG_EN_BIT); // RULE1
      input_short_cal_q  <= 1'(`FGC_CFG_RESET >> `FGC_CFG_CAL_BIT); // RULE2
      latch_source_sel_q <= FGC_SRC_CMD; // RULE3
      current_dir_flag_q <= 1'b0;
    end else begin
      gauge_enable_bit_q <= gauge_enable_bit_d;
      input_short_cal_q  <= input_short_cal_d;
      latch_source_sel_q <= latch_source_sel_d;
      current_dir_flag_q <= current_dir_flag_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  // Fed from the next config value so the pins move on the write edge itself
  // Calibration and the high impedance request share one bit on purpose
  always_comb begin
    en_out_d  = gauge_enable_bit_d; // RULE1
    cal_out_d = input_short_cal_d; // RULE2
    hiz_d     = input_short_cal_d; // RULE2
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      en_out_q  <= 1'(`FGC_CFG_RESET >> `FGC_CFG_EN_BIT); // RULE1
      cal_out_q <= 1'(`FGC_CFG_RESET >> `FGC_CFG_CAL_BIT); // RULE2
      hiz_q     <= 1'(`FGC_CFG_RESET >> `FGC_CFG_CAL_BIT); // RULE2
    end else begin
      en_out_q  <= en_out_d;
      cal_out_q <= cal_out_d;
      hiz_q     <= hiz_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Snapshot latches
  // Counters are registered words, so the copy is always whole; a tick in the
  // latch cycle lands in the counter after the copy is taken
  always_comb begin
    dis_latch_d = dis_latch_q;
    chg_latch_d = chg_latch_q;
    if (latch_evt) begin
      dis_latch_d = dis_cnt; // RULE18
      chg_latch_d = chg_cnt; // RULE18
    end
  end

  // Latching reads the counters only; they keep running
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dis_latch_q <= `FGC_LATCH_RESET; // RULE13
      chg_latch_q <= `FGC_LATCH_RESET; // RULE14
    end else begin
      dis_latch_q <= dis_latch_d; // RULE17
      chg_latch_q <= chg_latch_d; // RULE17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read byte views
  // Latch bytes are plain slices: the latches only move on a latch event, so
  // a low/high pair read between two events always belongs to one count
  always_comb begin
    cfg_byte                                  = 8'h00; // RULE20
    cfg_byte[`FGC_CFG_EN_BIT]                 = gauge_enable_bit_q; // RULE1
    cfg_byte[`FGC_CFG_CAL_BIT]                = input_short_cal_q; // RULE2
    cfg_byte[`FGC_CFG_SEL_HI:`FGC_CFG_SEL_LO] = latch_source_sel_q; // RULE3
    cfg_byte[`FGC_CFG_DIR_BIT]                = current_dir_flag_q; // RULE8
    dis_lo_byte                               = dis_latch_q[7:0]; // RULE13
    dis_hi_byte                               = dis_latch_q[15:8]; // RULE13
    chg_lo_byte                               = chg_latch_q[7:0]; // RULE14
    chg_hi_byte                               = chg_latch_q[15:8]; // RULE14
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  // Read data is registered: it appears one edge after the strobe and holds
  always_comb begin
    rdata_d = rdata_q;
    if (port_rd_i) begin
      if (hit_cfg) begin
        rdata_d = cfg_byte; // RULE8
      end else if (hit_dis_lo) begin
        rdata_d = dis_lo_byte; // RULE13
      end else if (hit_dis_hi) begin
        rdata_d = dis_hi_byte; // RULE13
      end else if (hit_chg_lo) begin
        rdata_d = chg_lo_byte; // RULE14
      end else if (hit_chg_hi) begin
        rdata_d = chg_hi_byte; // RULE14
      end else begin
        // Command register is write only; unmapped offsets read zero
        rdata_d = 8'h00; // RULE19
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_q <= `FGC_RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign port_rdata_o      = rdata_q;
  assign gauge_enable_o    = en_out_q;
  assign input_short_cal_o = cal_out_q;
  assign sense_pos_hiz_o   = hiz_q; // RULE2
  assign charge_ovf_o      = chg_ovf; // RULE16
  assign discharge_ovf_o   = dis_ovf; // RULE16

endmodule

// ### verif/fgc_regs_asserts.sv
// Port-level checker of the fuel gauge register block
`timescale 1ns/1ps
`include "fgc_defines.svh"
module fgc_regs_asserts #(
  parameter int CNT_W = 16
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] port_addr_i,
  input  wire logic [7:0] port_wdata_i,
  input  wire logic       port_wr_i,
  input  wire logic       port_rd_i,
  input  wire logic [7:0] port_rdata_o,
  input  wire logic       charge_tick_i,
  input  wire logic       discharge_tick_i,
  input  wire logic       gauge_enable_o,
  input  wire logic       input_short_cal_o,
  input  wire logic       sense_pos_hiz_o,
  input  wire logic       charge_ovf_o,
  input  wire logic       discharge_ovf_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic cfg_wr;
  logic cfg_rd;
  assign cfg_wr = port_wr_i && (port_addr_i == `FGC_ADDR_CONFIG);
  assign cfg_rd = port_rd_i && (port_addr_i == `FGC_ADDR_CONFIG);
  ////////////////////////////////////////////////////////////////////////////////
  AST_EN_RESET: assert property ($fell(srst_i) |-> !gauge_enable_o && !input_short_cal_o)
    else $error("gauge not off after reset");
  AST_EN_WR: assert property (cfg_wr |=> gauge_enable_o == $past(port_wdata_i[7]))
    else $error("enable does not follow write");
  AST_CAL_WR: assert property (cfg_wr |=> input_short_cal_o == $past(port_wdata_i[6]))
    else $error("calibration does not follow write");
  AST_HIZ: assert property (sense_pos_hiz_o == input_short_cal_o)
    else $error("sense high impedance differs from calibration");
  AST_CFG_HOLD: assert property (!cfg_wr |=> $stable(gauge_enable_o))
    else $error("enable changed without write");
  AST_CFG_RD: assert property (cfg_rd |=> port_rdata_o[7] == $past(gauge_enable_o)
    && port_rdata_o[6] == $past(input_short_cal_o))
    else $error("config read differs from outputs");
  AST_RSV_RD: assert property (cfg_rd |=> port_rdata_o[2:0] == 3'h0)
    else $error("reserved config bits not zero");
  AST_WO_RD: assert property (port_rd_i && port_addr_i == `FGC_ADDR_COMMAND
    |=> port_rdata_o == 8'h00)
    else $error("command register readable");
  AST_RD_HOLD: assert property (!port_rd_i |=> $stable(port_rdata_o))
    else $error("read data changed without read");
  AST_COVF: assert property (charge_ovf_o |-> $past(charge_tick_i)
    && $past(gauge_enable_o) ##1 !charge_ovf_o)
    else $error("bad charge wrap pulse");
  AST_DOVF: assert property (discharge_ovf_o |-> $past(discharge_tick_i)
    && $past(gauge_enable_o) ##1 !discharge_ovf_o)
    else $error("bad discharge wrap pulse");
  cover property (cfg_wr);
  cover property (charge_ovf_o);
  cover property (port_rd_i && port_addr_i == `FGC_ADDR_CHG_HIGH);
endmodule

bind fgc_regs fgc_regs_asserts #(.CNT_W(CNT_W)) i_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .port_addr_i(port_addr_i),
  .port_wdata_i(port_wdata_i), .port_wr_i(port_wr_i), .port_rd_i(port_rd_i),
  .port_rdata_o(port_rdata_o), .charge_tick_i(charge_tick_i),
  .discharge_tick_i(discharge_tick_i), .gauge_enable_o(gauge_enable_o),
  .input_short_cal_o(input_short_cal_o), .sense_pos_hiz_o(sense_pos_hiz_o),
  .charge_ovf_o(charge_ovf_o), .discharge_ovf_o(discharge_ovf_o));

// ### verif/fgc_host_model.sv
// Processor side model driving the peripheral port
`timescale 1ns/1ps
module fgc_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] port_rdata_i,
  output logic      [7:0] port_addr_o,
  output logic      [7:0] port_wdata_o,
  output logic            port_wr_o,
  output logic            port_rd_o,
  output logic            rd_valid_o,
  output logic      [7:0] rd_data_o
);
  logic rd_q = 1'b0;
  initial begin
    port_addr_o = 8'h00;
    port_wdata_o = 8'h00;
    port_wr_o = 1'b0;
    port_rd_o = 1'b0;
  end
  // Read data is registered, so it is taken one edge after the strobe
  always @(posedge sys_clk_i) begin
    rd_q <= port_rd_o;
    rd_valid_o <= rd_q;
    rd_data_o <= port_rdata_i;
  end
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(posedge sys_clk_i);
    port_addr_o <= a;
    port_wdata_o <= d;
    port_wr_o <= !rd;
    port_rd_o <= rd;
    @(posedge sys_clk_i);
    port_wr_o <= 1'b0;
    port_rd_o <= 1'b0;
    // Idle bus shows inverted values, never the stale ones
    port_addr_o <= ~a;
    port_wdata_o <= ~d;
  endtask
endmodule

// ### verif/fgc_regs_tb.sv
// Self-checking bench of the fuel gauge register block
`timescale 1ns/1ps
`include "fgc_defines.svh"
module fgc_regs_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr, wdata, rdata, rd_data, e;
  logic wr, rd, rd_valid;
  logic ctick = 1'b0, dtick = 1'b0, dir = 1'b1, busy = 1'b0, ta = 1'b0, tbo = 1'b0;
  logic [15:0] chg_m = 16'h0000, dis_m = 16'h0000, lc = 16'h0000, ld = 16'h0000;
  logic en_m = 1'b0;
  logic covf, dovf;
  int covf_n = 0, dovf_n = 0;
  logic [31:0] seed = 32'h9c2a_561d;
  logic [7:0] expq[$];
  logic [7:0] ra[7] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h20};
  int bad_count = 0, checks = 0;
  fgc_host_model i_host (.sys_clk_i(clk), .port_rdata_i(rdata), .port_addr_o(addr),
    .port_wdata_o(wdata), .port_wr_o(wr), .port_rd_o(rd), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data));
  fgc_regs #(.CNT_W(16)) i_dut (.sys_clk_i(clk), .srst_i(srst), .port_addr_i(addr),
    .port_wdata_i(wdata), .port_wr_i(wr), .port_rd_i(rd), .port_rdata_o(rdata),
    .charge_tick_i(ctick), .discharge_tick_i(dtick), .dir_charge_i(dir),
    .adc_busy_i(busy), .timer_a_ovf_i(ta), .timer_b_ovf_i(tbo), .gauge_enable_o(),
    .input_short_cal_o(), .sense_pos_hiz_o(), .charge_ovf_o(covf), .discharge_ovf_o(dovf));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
    expq.push_back(x);
    i_host.xfer(a, 8'h00, 1'b1);
  endtask
  task automatic lat_chk;
    rd_exp(`FGC_ADDR_DIS_LOW, ld[7:0]);
    rd_exp(`FGC_ADDR_DIS_HIGH, ld[15:8]);
    rd_exp(`FGC_ADDR_CHG_LOW, lc[7:0]);
    rd_exp(`FGC_ADDR_CHG_HIGH, lc[15:8]);
  endtask
  task automatic latch_now;
    ld = dis_m;
    lc = chg_m;
    lat_chk();
  endtask
  task automatic snap;
    i_host.xfer(`FGC_ADDR_COMMAND, 8'h80, 1'b0);
    latch_now();
  endtask
  // Ticks stop before returning so the model counts are final
  task automatic tick(input int n, input logic all);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      @(posedge clk);
      ctick <= all | seed[0];
      dtick <= all | seed[1];
      if (en_m) begin
        chg_m += 16'(all | seed[0]);
        dis_m += 16'(all | seed[1]);
      end
    end
    @(posedge clk);
    ctick <= 1'b0;
    dtick <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Wrap pulses last one cycle, so each is seen at exactly one edge
  always @(posedge clk) begin
    if (covf === 1'b1) covf_n++;
    if (dovf === 1'b1) dovf_n++;
  end
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      e = expq.pop_front();
      checks++;
      if (rd_data !== e) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, rd_data, e);
      end
    end
  end
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) rd_exp(ra[i], (i == 0) ? 8'h08 : 8'h00);
    $display("test reset done");
    dir <= 1'b0;
    i_host.xfer(`FGC_ADDR_CONFIG, 8'h4F, 1'b0);
    tick(20, 1'b0);
    rd_exp(`FGC_ADDR_CONFIG, 8'h40);
    i_host.xfer(`FGC_ADDR_CONFIG, 8'h80, 1'b0);
    en_m = 1'b1;
    tick(30, 1'b0);
    snap();
    tick(10, 1'b0);
    lat_chk();
    i_host.xfer(`FGC_ADDR_COMMAND, 8'h1F, 1'b0);
    lat_chk();
    snap();
    i_host.xfer(`FGC_ADDR_COMMAND, 8'h5F, 1'b0);
    dis_m = 16'h0000;
    snap();
    i_host.xfer(`FGC_ADDR_COMMAND, 8'h20, 1'b0);
    chg_m = 16'h0000;
    snap();
    $display("test commands done");
    for (int m = 1; m < 4; m++) begin
      i_host.xfer(`FGC_ADDR_CONFIG, {2'b10, 2'(m), 4'h0}, 1'b0);
      rd_exp(`FGC_ADDR_CONFIG, {2'b10, 2'(m), 4'h0});
      tick(8, 1'b1);
      i_host.xfer(`FGC_ADDR_COMMAND, 8'hE0, 1'b0);
      lat_chk();
      @(posedge clk);
      busy <= (m == 1);
      ta <= (m == 2);
      tbo <= (m == 3);
      repeat (3) @(posedge clk);
      ta <= 1'b0;
      tbo <= 1'b0;
      latch_now();
      if (m == 1) begin
        tick(5, 1'b1);
        busy <= 1'b0;
        repeat (3) @(posedge clk);
        latch_now();
      end
    end
    $display("test sources done");
    i_host.xfer(`FGC_ADDR_CONFIG, 8'h80, 1'b0);
    i_host.xfer(`FGC_ADDR_COMMAND, 8'h60, 1'b0);
    chg_m = 16'h0000;
    dis_m = 16'h0000;
    tick(65537, 1'b1);
    snap();
    checks++;
    if (covf_n != 1 || dovf_n != 1) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time,
        {4'(covf_n), 4'(dovf_n)}, 8'h11);
    end
    $display("test wrap done");
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
